// >>> verification/pci_master_model.sv
// Behavioural model of the secondary bus masters
`timescale 1ns/100ps
module pci_master_model (
    input  wire logic       clock_in,    // Bus clock
    input  wire logic       rst_b_in,    // Async reset, active low
    input  wire logic [5:0] gnt_b_in,    // Grants from arbiter, low
    input  wire logic [5:0] want_in,     // Masters wanting the bus
    input  wire logic [5:0] live_in,     // Masters that answer a grant
    output logic      [5:0] req_b_out,   // Requests, low
    output logic            frame_b_out, // FRAME, low, pulled up
    output logic            irdy_b_out   // IRDY, low, pulled up
);
    logic [1:0] phase_ff; // Transfer phase

    // Request follows the wish of each master
    assign req_b_out = ~want_in;

    //////////////////////////////////////////////////////////////////////
    // One-data-phase transfer by a granted live master on an idle bus
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_ff    <= 2'h0;
            frame_b_out <= 1'b1;
            irdy_b_out  <= 1'b1;
        end else if (phase_ff == 2'h0) begin
            if ((~gnt_b_in & live_in) != 6'h00) begin
                frame_b_out <= 1'b0;
                irdy_b_out  <= 1'b0;
                phase_ff    <= 2'h1;
            end
        end else if (phase_ff == 2'h1) begin
            frame_b_out <= 1'b1; // Last data phase
            phase_ff    <= 2'h2;
        end else begin
            irdy_b_out <= 1'b1;  // Released lines go to pull-up level
            phase_ff   <= 2'h0;
        end
    end
endmodule // pci_master_model

// >>> verification/tb.sv
// Self-checking testbench of the mask and time-out arbiter
`timescale 1ns/100ps
module tb;
    import arb_mask_pkg::*;
    logic       clock_in = 1'b0;  // Bus clock
    logic       rst_b_in = 1'b0;  // Power-on reset
    logic       glob     = 1'b0;  // Global reset pin
    logic [5:0] want     = 6'h00; // Masters wanting the bus
    logic [5:0] live     = 6'h00; // Masters that answer
    logic       bridge_req = 1'b0; // Bridge own request
    logic [6:0] tier_hi  = 7'h7F; // Tier per requester
    logic [7:0] cfg_addr_in = 8'h00;
    logic       cfg_wr_in   = 1'b0;
    logic [7:0] cfg_wdata_in = 8'h00;
    logic [5:0] req_b, gnt_b_out;
    logic       frame_b, irdy_b, bridge_gnt;
    logic [7:0] cfg_rdata_out, rd;
    int         err_total = 0;
    int         checks = 0;
    int         n;

    always #20 clock_in = ~clock_in;

    secondary_arbiter_mask_timeout u_dut (
        .clock_in(clock_in), .rst_b_in(rst_b_in),
        .global_reset_input_in(glob), .req_b_in(req_b),
        .frame_b_in(frame_b), .irdy_b_in(irdy_b),
        .bridge_req_in(bridge_req), .tier_high_in(tier_hi),
        .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in),
        .cfg_wdata_in(cfg_wdata_in), .gnt_b_out(gnt_b_out),
        .bridge_gnt_out(bridge_gnt), .cfg_rdata_out(cfg_rdata_out));

    pci_master_model u_masters (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .gnt_b_in(gnt_b_out),
        .want_in(want), .live_in(live), .req_b_out(req_b),
        .frame_b_out(frame_b), .irdy_b_out(irdy_b));

    //////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_n(string what, int exp, int got);
        checks++;
        if (got != exp) begin
            err_total++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock_in);
        cfg_addr_in  <= a;
        cfg_wdata_in <= d;
        cfg_wr_in    <= 1'b1;
        @(posedge clock_in);
        cfg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic rdreg(logic [7:0] a);
        @(posedge clock_in);
        cfg_addr_in <= a;
        repeat (2) @(posedge clock_in);
        #1 rd = cfg_rdata_out;
    endtask

    // Count edges until grant idx reaches lvl, bounded
    task automatic wait_gnt(int idx, logic lvl);
        n = 0;
        while (gnt_b_out[idx] !== lvl) begin
            @(posedge clock_in);
            #1 n++;
            if (n > 200) begin
                err_total++;
                $display("unexpected grant wait: expected %b", lvl);
                give_verdict();
            end
        end
    endtask

    // Wait for any master grant, bounded
    task automatic wait_any();
        n = 0;
        while (gnt_b_out === 6'h3F) begin
            @(posedge clock_in);
            #1 n++;
            if (n > 200) begin
                err_total++;
                $display("unexpected any grant: expected one seen none");
                give_verdict();
            end
        end
    endtask

    //////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rdreg(ADDR_MASK_CTL);
        chk8("mask reset", 8'h00, rd);
        rdreg(ADDR_EXPIRY);
        chk8("flags reset", 8'h00, rd);
        $display("test reset done");
    endtask

    task automatic t_mask();
        wr(ADDR_MASK_CTL, 8'h3F);
        rdreg(ADDR_MASK_CTL);
        chk8("mask rw", 8'h3F, rd);
        @(posedge clock_in) want <= 6'h08;
        live <= 6'h08;
        repeat (30) @(posedge clock_in);
        #1 chk8("masked grant", 8'h3F, {2'h0, gnt_b_out});
        wr(ADDR_MASK_CTL, 8'h00);
        wait_gnt(3, 1'b0);
        chk8("unmasked grant", 8'h37, {2'h0, gnt_b_out});
        @(posedge clock_in) want <= 6'h00;
        wait_gnt(3, 1'b1);
        wr(ADDR_EXPIRY, 8'hFF);
        rdreg(ADDR_EXPIRY);
        chk8("flags reserved", 8'h00, rd);
        wr(8'h10, 8'h55);
        rdreg(8'h10);
        chk8("unmapped", UNMAPPED_RDATA, rd);
        $display("test mask done");
    endtask

    task automatic t_no_watch();
        @(posedge clock_in) want <= 6'h04;
        live <= 6'h00;
        wait_gnt(2, 1'b0);
        repeat (40) @(posedge clock_in);
        #1 chk8("held grant", 8'h00, {7'h0, gnt_b_out[2]});
        rdreg(ADDR_EXPIRY);
        chk8("no flag", 8'h00, rd);
        @(posedge clock_in) want <= 6'h00;
        wait_gnt(2, 1'b1);
        $display("test watch off done");
    endtask

    task automatic t_timeout();
        wr(ADDR_MASK_CTL, 8'hC0);
        @(posedge clock_in) want <= 6'h01;
        wait_gnt(0, 1'b0);
        wait_gnt(0, 1'b1);
        chk_n("grant span", TIMEOUT_CLOCKS + 1, n);
        rdreg(ADDR_EXPIRY);
        chk8("flag set", 8'h01, rd);
        rdreg(ADDR_MASK_CTL);
        chk8("auto mask", 8'hC1, rd);
        @(posedge clock_in) want <= 6'h02;
        live <= 6'h02;
        wait_gnt(1, 1'b0);
        @(posedge clock_in) want <= 6'h00;
        wr(ADDR_EXPIRY, 8'h00);
        rdreg(ADDR_EXPIRY);
        chk8("write 0 kept", 8'h01, rd);
        wr(ADDR_EXPIRY, 8'h01);
        rdreg(ADDR_EXPIRY);
        chk8("locked flag", 8'h01, rd);
        wr(ADDR_MASK_CTL, 8'h81);
        wr(ADDR_EXPIRY, 8'h01);
        rdreg(ADDR_EXPIRY);
        chk8("flag cleared", 8'h00, rd);
        wr(ADDR_MASK_CTL, 8'h00);
        $display("test time-out done");
    endtask

    task automatic t_global_reset_input();
        wr(ADDR_MASK_CTL, 8'hC5);
        @(posedge clock_in) glob <= 1'b1;
        repeat (3) @(posedge clock_in);
        glob <= 1'b0;
        repeat (4) @(posedge clock_in);
        rdreg(ADDR_MASK_CTL);
        chk8("global reset", 8'h00, rd);
        $display("test global reset done");
    endtask

    task automatic t_tier();
        @(posedge clock_in) tier_hi <= 7'h7E;      // Master 0 in low tier
        want <= 6'h03;
        live <= 6'h03;
        wait_any();
        chk8("high tier first", 8'h3D, {2'h0, gnt_b_out});
        @(posedge clock_in) want <= 6'h01;
        wait_gnt(0, 1'b0);
        chk8("low tier served", 8'h3E, {2'h0, gnt_b_out});
        wr(ADDR_MASK_CTL, 8'h80);
        @(posedge clock_in) bridge_req <= 1'b1;
        want <= 6'h00;
        repeat (40) @(posedge clock_in);
        #1;
        chk8("bridge on", 8'h7F, {1'b0, bridge_gnt, gnt_b_out});
        rdreg(ADDR_EXPIRY);
        chk8("bridge not flagged", 8'h00, rd);
        @(posedge clock_in) bridge_req <= 1'b0;
        repeat (4) @(posedge clock_in);
        #1;
        chk8("bridge off", 8'h3F, {1'b0, bridge_gnt, gnt_b_out});
        wr(ADDR_MASK_CTL, 8'h00);
        @(posedge clock_in) tier_hi <= 7'h7F;
        live <= 6'h00;
        $display("test tier done");
    endtask

    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge clock_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_mask();
        t_no_watch();
        t_timeout();
        t_global_reset_input();
        t_tier();
        give_verdict();
    end
endmodule // tb

// >>> verilog/arb_mask_pkg.sv
// Constants and types for the secondary arbiter mask and time-out block
package arb_mask_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] ADDR_MASK_CTL   = 8'hDD;
    localparam logic [7:0] ADDR_EXPIRY     = 8'hDE;
    localparam logic [7:0] MASK_CTL_RESET  = 8'h00;
    localparam logic [7:0] EXPIRY_RESET    = 8'h00;
    localparam logic [7:0] EXPIRY_RD_MASK  = 8'h3F;
    localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

    // Field positions in the mask register
    localparam int WATCH_EN_BIT  = 7;
    localparam int AUTO_MASK_BIT = 6;

    ////////////////////////////////////////////////////////////////////////
    // Requesters and timing
    localparam int          NUM_MASTERS    = 6;
    localparam int          NUM_REQ        = 7;
    localparam int          IDX_W          = 3;
    localparam logic [2:0]  BRIDGE_IDX     = 3'h6;
    localparam int          TIMEOUT_CLOCKS = 16;
    localparam int          TIMER_W        = 5;
    localparam logic [6:0]  GNT_NONE       = 7'h7F;

    // Arbiter sequencing
    typedef enum logic [1:0] {
        S_ARB,
        S_GRANTED,
        S_BUSY
    } arb_state_t;

endpackage

// >>> verilog/grant_watch_timer.sv
// Idle-bus counter that flags a silent granted master
`timescale 1ns/100ps
module grant_watch_timer
    import arb_mask_pkg::*;
#(
    parameter int LIMIT = TIMEOUT_CLOCKS,
    parameter int CW    = TIMER_W
) (
    input  wire logic clock_in,    // Bus clock
    input  wire logic rst_b_in,    // Async reset, active low
    input  wire logic run_in,      // Watch condition holds
    output logic      expired_out  // One-cycle time-out pulse
);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          expired;
    } timer_state_t;

    timer_state_t q;
    timer_state_t n;

    // Count clocks while the watch holds, restart when it breaks
    always_comb begin
        n         = q;
        n.expired = 1'b0;
        if (!run_in) begin
            n.cnt = '0;
        end else begin
            if (q.cnt == CW'(LIMIT - 1)) begin
                n.expired = 1'b1;
            end
            if (q.cnt != CW'(LIMIT)) begin
                n.cnt = q.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign expired_out = q.expired;

endmodule // grant_watch_timer

// >>> verilog/request_rotator.sv
// Rotating pick among one tier of requesters
`timescale 1ns/100ps
module request_rotator
    import arb_mask_pkg::*;
#(
    parameter int N  = NUM_REQ,
    parameter int IW = IDX_W
) (
    input  wire logic [N-1:0]  req_in,   // Requests of this tier
    input  wire logic [IW-1:0] last_in,  // Last owner in this tier
    output logic      [IW-1:0] pick_out, // Next owner
    output logic               any_out   // Some request present
);

    // Search from the one after the last owner, nearest wins
    always_comb begin
        int idx;
        idx      = 0;
        pick_out = last_in;
        any_out  = 1'b0;
        for (int k = N; k >= 1; k--) begin
            idx = (int'(last_in) + k) % N;
            if (req_in[idx]) begin
                pick_out = IW'(idx);
                any_out  = 1'b1;
            end
        end
    end

endmodule // request_rotator

// >>> verilog/secondary_arbiter_mask_timeout.sv
// Secondary bus arbiter with request masking and grant time-out
`timescale 1ns/100ps
module secondary_arbiter_mask_timeout
    import arb_mask_pkg::*;
(
    input  wire logic       clock_in,        // Bus clock, 25 MHz
    input  wire logic       rst_b_in,        // Power-on/express rst
    input  wire logic       global_reset_input_in, // Global reset pin
    input  wire logic [5:0] req_b_in,        // Master requests, low
    input  wire logic       frame_b_in,      // FRAME pin, low
    input  wire logic       irdy_b_in,       // IRDY pin, low
    input  wire logic       bridge_req_in,   // Bridge own request
    input  wire logic [6:0] tier_high_in,    // Tier per requester
    input  wire logic [7:0] cfg_addr_in,     // Config address
    input  wire logic       cfg_wr_in,       // Config write strobe
    input  wire logic [7:0] cfg_wdata_in,    // Config write data
    output logic      [5:0] gnt_b_out,       // Master grants, low
    output logic            bridge_gnt_out,  // Bridge own grant
    output logic      [7:0] cfg_rdata_out    // Config read data
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [5:0]  req_s1;
        logic [5:0]  req_s2;
        logic        frame_s1;
        logic        frame_s2;
        logic        irdy_s1;
        logic        irdy_s2;
        logic        gsync_s1;
        logic        gsync_s2;
        logic [7:0]  mask_ctl;
        logic [5:0]  flags;
        logic        locked;
        arb_state_t  state;
        logic [2:0]  owner;
        logic [2:0]  last_hi;
        logic [2:0]  last_lo;
        logic [6:0]  gnt_b;
        logic        bridge_gnt;
        logic [7:0]  rdata;
    } arb_regs_t;

    arb_regs_t q;
    arb_regs_t n;

    logic       bus_idle;
    logic       watch_run;
    logic       timer_expired;
    logic       expiry_hit;
    logic [6:0] eff_req;
    logic [6:0] hi_req;
    logic [6:0] lo_req;
    logic [2:0] hi_pick;
    logic [2:0] lo_pick;
    logic       hi_any;
    logic       lo_any;
    logic [5:0] owner_bit;
    logic       wr_mask;
    logic       wr_flags;

    ////////////////////////////////////////////////////////////////////////
    // Request qualification and tier split
    assign bus_idle  = q.frame_s2 && q.irdy_s2;
    assign eff_req   = {bridge_req_in, ~q.req_s2 & ~q.mask_ctl[5:0]};
    assign hi_req    = eff_req & tier_high_in;
    assign lo_req    = eff_req & ~tier_high_in;
    assign owner_bit = 6'(7'h01 << q.owner);
    assign wr_mask   = cfg_wr_in && (cfg_addr_in == ADDR_MASK_CTL);
    assign wr_flags  = cfg_wr_in && (cfg_addr_in == ADDR_EXPIRY);

    // Watch only a granted master while the bus sits idle
    assign watch_run = q.mask_ctl[WATCH_EN_BIT] && (q.state == S_GRANTED)
                       && (q.owner != BRIDGE_IDX) && bus_idle;
    assign expiry_hit = timer_expired && q.mask_ctl[WATCH_EN_BIT]
                        && (q.state == S_GRANTED);

    request_rotator #(
        .N  (NUM_REQ),
        .IW (IDX_W)
    ) u_hi_tier (
        .req_in   (hi_req),
        .last_in  (q.last_hi),
        .pick_out (hi_pick),
        .any_out  (hi_any)
    );

    request_rotator #(
        .N  (NUM_REQ),
        .IW (IDX_W)
    ) u_lo_tier (
        .req_in   (lo_req),
        .last_in  (q.last_lo),
        .pick_out (lo_pick),
        .any_out  (lo_any)
    );

    grant_watch_timer #(
        .LIMIT (TIMEOUT_CLOCKS),
        .CW    (TIMER_W)
    ) u_watch (
        .clock_in    (clock_in),
        .rst_b_in    (rst_b_in),
        .run_in      (watch_run),
        .expired_out (timer_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n = q;
        // Pin synchronisers
        n.req_s1   = req_b_in;
        n.req_s2   = q.req_s1;
        n.frame_s1 = frame_b_in;
        n.frame_s2 = q.frame_s1;
        n.irdy_s1  = irdy_b_in;
        n.irdy_s2  = q.irdy_s1;
        n.gsync_s1 = global_reset_input_in;
        n.gsync_s2 = q.gsync_s1;

        // Mask register write
        if (wr_mask) begin
            n.mask_ctl = cfg_wdata_in;
        end
        // Lock releases once automatic masking is off
        if (!q.mask_ctl[AUTO_MASK_BIT]) begin
            n.locked = 1'b0;
        end
        // Write one to clear, refused while locked
        if (wr_flags && !q.locked) begin
            n.flags = q.flags & ~cfg_wdata_in[5:0];
        end

        // Grant sequencing
        unique case (q.state)
            S_ARB: begin
                n.gnt_b = GNT_NONE;
                if (bus_idle && (hi_any || lo_any)) begin
                    n.owner = hi_any ? hi_pick : lo_pick;
                    if (hi_any) begin
                        n.last_hi = hi_pick;
                    end else begin
                        n.last_lo = lo_pick;
                    end
                    n.gnt_b = GNT_NONE & ~7'(7'h01 << n.owner);
                    n.state = S_GRANTED;
                end
            end
            S_GRANTED: begin
                if (expiry_hit) begin
                    // Silent master loses the grant
                    n.flags = n.flags | owner_bit;
                    if (q.mask_ctl[AUTO_MASK_BIT]) begin
                        n.mask_ctl[5:0] = n.mask_ctl[5:0] | owner_bit;
                        n.locked        = 1'b1;
                    end
                    n.gnt_b = GNT_NONE;
                    n.state = S_ARB;
                end else if (!q.frame_s2) begin
                    n.gnt_b = GNT_NONE;
                    n.state = S_BUSY;
                end else if (!eff_req[q.owner]) begin
                    n.gnt_b = GNT_NONE;
                    n.state = S_ARB;
                end
            end
            S_BUSY: begin
                if (bus_idle) begin
                    n.state = S_ARB;
                end
            end
            default: begin
                n.gnt_b = GNT_NONE;
                n.state = S_ARB;
            end
        endcase

        // Global reset returns control and flags to defaults
        if (q.gsync_s2) begin
            n.mask_ctl = MASK_CTL_RESET;
            n.flags    = EXPIRY_RESET[5:0];
            n.locked   = 1'b0;
            n.gnt_b    = GNT_NONE;
            n.state    = S_ARB;
        end

        // Bridge grant kept active high in its own flop
        n.bridge_gnt = ~n.gnt_b[6];

        // Registered read data
        if (cfg_addr_in == ADDR_MASK_CTL) begin
            n.rdata = q.mask_ctl;
        end else if (cfg_addr_in == ADDR_EXPIRY) begin
            n.rdata = {2'b00, q.flags} & EXPIRY_RD_MASK;
        end else begin
            n.rdata = UNMAPPED_RDATA;
        end
    end

    // State register; async reset gives the defaults
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q          <= '0;
            q.req_s1   <= 6'h3F;
            q.req_s2   <= 6'h3F;
            q.frame_s1 <= 1'b1;
            q.frame_s2 <= 1'b1;
            q.irdy_s1  <= 1'b1;
            q.irdy_s2  <= 1'b1;
            q.mask_ctl <= MASK_CTL_RESET;
            q.flags    <= EXPIRY_RESET[5:0];
            q.state    <= S_ARB;
            q.owner    <= BRIDGE_IDX;
            q.last_hi  <= BRIDGE_IDX;
            q.last_lo  <= BRIDGE_IDX;
            q.gnt_b    <= GNT_NONE;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from flops
    assign gnt_b_out      = q.gnt_b[5:0];
    assign bridge_gnt_out = q.bridge_gnt;
    assign cfg_rdata_out  = q.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    chk_watch_off_quiet: assert property (
        !q.mask_ctl[WATCH_EN_BIT] |=> ((q.flags & ~$past(q.flags)) == 6'h00))
        else $error("flag set with watch disabled");

    chk_expiry_sixteen: assert property (
        timer_expired |-> ($past(watch_run, 1) && $past(watch_run, 8)
                           && $past(watch_run, 16)))
        else $error("time-out without sixteen idle clocks");

    chk_expiry_needs_run: assert property (
        !watch_run |=> !timer_expired)
        else $error("time-out after watch broke");

    chk_auto_mask_set: assert property (
        (expiry_hit && q.mask_ctl[AUTO_MASK_BIT] && !q.gsync_s2)
        |=> q.mask_ctl[$past(q.owner)])
        else $error("silent requester not masked");

    chk_masked_not_granted: assert property (
        ($changed(q.gnt_b) && (q.gnt_b != GNT_NONE))
        |-> (($past(q.mask_ctl[5:0]) & ~q.gnt_b[5:0]) == 6'h00))
        else $error("grant given to masked requester");

    chk_flag_on_expiry: assert property (
        (expiry_hit && !q.gsync_s2) |=> q.flags[$past(q.owner)])
        else $error("time-out flag not set");

    chk_flag_sticky: assert property (
        (!wr_flags && !q.gsync_s2) |=> ((q.flags & $past(q.flags))
                                        == $past(q.flags)))
        else $error("flag cleared without write");

    chk_locked_flags: assert property (
        (q.locked && !q.gsync_s2) |=> ((q.flags & $past(q.flags))
                                       == $past(q.flags)))
        else $error("flag cleared while locked");

    chk_reserved_zero: assert property (
        ($past(cfg_addr_in) == ADDR_EXPIRY) |-> (q.rdata[7:6] == 2'b00))
        else $error("reserved flag bits read nonzero");

    chk_global_reset: assert property (
        q.gsync_s2 |=> (q.mask_ctl == MASK_CTL_RESET))
        else $error("mask not cleared by global reset");

    chk_high_tier_first: assert property (
        (q.state == S_ARB && bus_idle && hi_any && !q.gsync_s2)
        |=> ((($past(hi_req) >> q.owner) & 7'h01) == 7'h01))
        else $error("low tier won over high tier");

    chk_grant_withdrawn: assert property (
        (expiry_hit && !q.gsync_s2) |=> (q.gnt_b == GNT_NONE) ##1
        (q.state == S_ARB || q.state == S_GRANTED))
        else $error("grant kept after time-out");

    chk_single_grant: assert property (
        $countones(~q.gnt_b) <= 1)
        else $error("more than one grant active");

    chk_no_early_expiry: assert property (
        $rose(watch_run) |=> !timer_expired [*8])
        else $error("time-out before sixteen idle clocks");

    chk_flag_write_clear: assert property (
        (wr_flags && !q.locked && !expiry_hit && !q.gsync_s2)
        |=> ((q.flags & $past(cfg_wdata_in[5:0])) == 6'h00))
        else $error("written flag not cleared");

endmodule // secondary_arbiter_mask_timeout
